// >>> rtl/limit_irq.sv
`include "mon_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module limit_irq (
  input wire logic clk, // device clock
  input wire logic nrst, // sync reset, active low
  input wire logic [3:0] ov_level, // over-limit per pin
  input wire logic [3:0] uv_level, // under-limit per pin
  input wire logic status_wr, // write one to clear
  input wire logic mask_wr, // mask write
  input wire logic [7:0] wdata, // write data
  output logic [7:0] status, // sticky events
  output logic [7:0] mask, // interrupt enables
  output logic irq // level interrupt
);
  import mon_pkg::*;

  logic [3:0] ov_prev;
  logic [3:0] uv_prev;
  logic [7:0] events;
  logic [7:0] next_status;
  logic [7:0] next_mask;

  always_comb begin
    events = 8'h00;
    events[`STAT_OV_LSB +: 4] = ov_level & ~ov_prev;
    events[`STAT_UV_LSB +: 4] = uv_level & ~uv_prev;
    next_status = status;
    if (status_wr) begin
      next_status = status & ~wdata;
    end
    // a rise in the clearing cycle is kept
    next_status = next_status | events;
    next_mask = mask_wr ? wdata : mask;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ov_prev <= 4'h0;
      uv_prev <= 4'h0;
      status <= `STATUS_RESET;
      mask <= `MASK_RESET;
    end else begin
      ov_prev <= ov_level;
      uv_prev <= uv_level;
      status <= next_status;
      mask <= next_mask;
    end
  end

  assign irq = |(status & mask);

endmodule
`default_nettype wire

// >>> rtl/mon_defs.svh
`ifndef MON_DEFS_SVH
`define MON_DEFS_SVH

// register byte addresses
`define SEL_A_ADDR 8'h00
`define SEL_B_ADDR 8'h04
`define STATUS_ADDR 8'h08
`define MASK_ADDR 8'h0c
`define FLAG_ADDR 8'h10
`define LIMIT_ADDR 8'h14

// select field positions (low bit of each 3-bit field)
`define PIN1_SEL_LSB 1
`define PIN2_SEL_LSB 5
`define PIN3_SEL_LSB 2
`define PIN4_SEL_LSB 5

// writable bits of the select registers and reset values of the select, status and mask registers
`define SEL_A_MASK 8'hee
`define SEL_B_MASK 8'hfc
`define SEL_A_RESET 8'h00
`define SEL_B_RESET 8'h00
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00

// status layout: over-limit rise per pin, then under-limit rise per pin
`define STAT_OV_LSB 0
`define STAT_UV_LSB 4

`endif

// >>> rtl/mon_pkg.sv
package mon_pkg;

  typedef enum logic [2:0] {
    MODE_SENSE_A = 3'h0,
    MODE_SENSE_B = 3'h1,
    MODE_POS_OV = 3'h2,
    MODE_POS_UV = 3'h3,
    MODE_NEG_OV = 3'h4,
    MODE_NEG_UV = 3'h5,
    MODE_FLAG = 3'h6,
    MODE_FLAG_INV = 3'h7
  } mon_mode_t;

endpackage

// >>> rtl/monitor_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module monitor_decoder (
  input wire logic clk, // device clock
  input wire logic nrst, // sync reset, active low
  input wire mon_pkg::mon_mode_t mode, // select code of this pin
  input wire logic above_1v15, // pin above 1.15 V
  input wire logic above_1v25, // pin above 1.25 V
  input wire logic above_1v35, // pin above 1.35 V
  output logic flag, // general flag
  output logic ov, // over-limit
  output logic uv // under-limit
);
  import mon_pkg::*;

  logic lo;
  logic hi;
  logic [2:0] below_val;
  logic [2:0] above_val;
  logic [2:0] next_fou;

  always_comb begin
    lo = 1'b0;
    hi = 1'b0;
    below_val = 3'h0;
    above_val = 3'h0;
    case (mode)
      MODE_POS_OV: begin
        lo = ~above_1v15;
        hi = above_1v25;
        above_val = 3'h6;
      end
      MODE_POS_UV: begin
        lo = ~above_1v25;
        hi = above_1v35;
        below_val = 3'h1;
        above_val = 3'h4;
      end
      MODE_NEG_OV: begin
        lo = ~above_1v25;
        hi = above_1v35;
        below_val = 3'h2;
        above_val = 3'h4;
      end
      MODE_NEG_UV: begin
        lo = ~above_1v15;
        hi = above_1v25;
        above_val = 3'h5;
      end
      MODE_FLAG: begin
        lo = ~above_1v15;
        hi = above_1v25;
        above_val = 3'h4;
      end
      MODE_FLAG_INV: begin
        lo = ~above_1v15;
        hi = above_1v25;
        below_val = 3'h4;
      end
      default: begin
      end
    endcase
  end

  // inside the hysteresis band the last decision holds
  always_comb begin
    if (mode == MODE_SENSE_A || mode == MODE_SENSE_B) begin
      next_fou = 3'h0;
    end else if (hi) begin
      next_fou = above_val;
    end else if (lo) begin
      next_fou = below_val;
    end else begin
      next_fou = {flag, ov, uv};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {flag, ov, uv} <= 3'h0;
    end else begin
      {flag, ov, uv} <= next_fou;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/monitor_pin_function_select.sv
// The implementer's own choices: the register offsets and the strobed register port.
`include "mon_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module monitor_pin_function_select (
  input wire logic clk, // device clock, 100 MHz
  input wire logic nrst, // sync reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [7:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd_en
  input wire logic [3:0] pin_level, // digital level of each pin
  input wire logic [3:0] above_1v15, // comparator per pin
  input wire logic [3:0] above_1v25, // comparator per pin
  input wire logic [3:0] above_1v35, // comparator per pin
  input wire logic power_good_in, // power good from fault logic
  output logic pin4_out, // pin four drive value
  output logic pin4_oe, // pin four output enable
  output logic mains_sense_input_one, // sense input one
  output logic mains_sense_input_two, // sense input two
  output logic power_on_request, // power-on request, high = on
  output logic [3:0] flag_out, // general flag per pin
  output logic [3:0] over_limit_output, // ov per pin
  output logic [3:0] under_limit_output, // uv per pin
  output logic irq // interrupt, high active
);
  import mon_pkg::*;

  logic [7:0] sel_a;
  logic [7:0] sel_b;
  logic [7:0] next_sel_a;
  logic [7:0] next_sel_b;
  logic [7:0] next_rdata;
  logic [7:0] status;
  logic [7:0] mask;
  logic pin1_select_bit2, pin1_select_bit1, pin1_select_bit0;
  logic pin2_select_bit2, pin2_select_bit1, pin2_select_bit0;
  logic pin3_select_bit2, pin3_select_bit1, pin3_select_bit0;
  logic pin4_select_bit2, pin4_select_bit1, pin4_select_bit0;
  mon_mode_t mode [4];
  logic next_sense_one;
  logic next_sense_two;
  logic next_power_on_request;
  logic next_pin4_out;
  logic next_pin4_oe;

  assign {pin1_select_bit2, pin1_select_bit1, pin1_select_bit0} =
    sel_a[`PIN1_SEL_LSB +: 3];
  assign {pin2_select_bit2, pin2_select_bit1, pin2_select_bit0} =
    sel_a[`PIN2_SEL_LSB +: 3];
  assign {pin3_select_bit2, pin3_select_bit1, pin3_select_bit0} =
    sel_b[`PIN3_SEL_LSB +: 3];
  assign {pin4_select_bit2, pin4_select_bit1, pin4_select_bit0} =
    sel_b[`PIN4_SEL_LSB +: 3];

  assign mode[0] = mon_mode_t'({pin1_select_bit2, pin1_select_bit1, pin1_select_bit0});
  assign mode[1] = mon_mode_t'({pin2_select_bit2, pin2_select_bit1, pin2_select_bit0});
  assign mode[2] = mon_mode_t'({pin3_select_bit2, pin3_select_bit1, pin3_select_bit0});
  assign mode[3] = mon_mode_t'({pin4_select_bit2, pin4_select_bit1, pin4_select_bit0});

  // register bus: reserved select bits are not stored and read as zero
  always_comb begin
    next_sel_a = sel_a;
    next_sel_b = sel_b;
    if (wr_en && addr == `SEL_A_ADDR) begin
      next_sel_a = wdata & `SEL_A_MASK;
    end
    if (wr_en && addr == `SEL_B_ADDR) begin
      next_sel_b = wdata & `SEL_B_MASK;
    end
    next_rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        `SEL_A_ADDR: next_rdata = sel_a;
        `SEL_B_ADDR: next_rdata = sel_b;
        `STATUS_ADDR: next_rdata = status;
        `MASK_ADDR: next_rdata = mask;
        `FLAG_ADDR: next_rdata = {4'h0, flag_out};
        `LIMIT_ADDR: next_rdata = {under_limit_output, over_limit_output};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_a <= `SEL_A_RESET;
      sel_b <= `SEL_B_RESET;
      rdata <= 8'h00;
    end else begin
      sel_a <= next_sel_a;
      sel_b <= next_sel_b;
      rdata <= next_rdata;
    end
  end

  // dedicated functions; inactive when the pin is a monitor
  always_comb begin
    next_sense_one = 1'b0;
    next_sense_two = 1'b0;
    next_power_on_request = 1'b0;
    next_pin4_out = 1'b0;
    next_pin4_oe = 1'b0;
    if (mode[0] == MODE_SENSE_A || mode[0] == MODE_SENSE_B) begin
      next_sense_one = pin_level[0];
    end
    if (mode[1] == MODE_SENSE_A || mode[1] == MODE_SENSE_B) begin
      next_sense_two = pin_level[1];
    end
    if (mode[2] == MODE_SENSE_A) begin
      next_power_on_request = ~pin_level[2];
    end else if (mode[2] == MODE_SENSE_B) begin
      next_power_on_request = pin_level[2];
    end
    if (mode[3] == MODE_SENSE_A || mode[3] == MODE_SENSE_B) begin
      next_pin4_oe = 1'b1;
      next_pin4_out = power_good_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mains_sense_input_one <= 1'b0;
      mains_sense_input_two <= 1'b0;
      power_on_request <= 1'b0;
      pin4_out <= 1'b0;
      pin4_oe <= 1'b0;
    end else begin
      mains_sense_input_one <= next_sense_one;
      mains_sense_input_two <= next_sense_two;
      power_on_request <= next_power_on_request;
      pin4_out <= next_pin4_out;
      pin4_oe <= next_pin4_oe;
    end
  end

  // one threshold decoder per pin; codes 000/001 hold it cleared
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      monitor_decoder u_dec (
        .clk(clk),
        .nrst(nrst),
        .mode(mode[gi]),
        .above_1v15(above_1v15[gi]),
        .above_1v25(above_1v25[gi]),
        .above_1v35(above_1v35[gi]),
        .flag(flag_out[gi]),
        .ov(over_limit_output[gi]),
        .uv(under_limit_output[gi])
      );
    end
  endgenerate

  limit_irq u_irq (
    .clk(clk),
    .nrst(nrst),
    .ov_level(over_limit_output),
    .uv_level(under_limit_output),
    .status_wr(wr_en && addr == `STATUS_ADDR),
    .mask_wr(wr_en && addr == `MASK_ADDR),
    .wdata(wdata),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

endmodule
`default_nettype wire

// >>> test/mon_pin_monitor.sv
`include "mon_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module mon_pin_monitor (
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic [7:0] addr, // address
  input wire logic [7:0] wdata, // data
  input wire logic wr_en, // write
  input wire logic [3:0] pin_level, // levels
  input wire logic [3:0] above_1v15, // cmp
  input wire logic [3:0] above_1v25, // cmp
  input wire logic [3:0] above_1v35, // cmp
  input wire logic power_good_in, // pg
  input wire logic pin4_out, // drive
  input wire logic pin4_oe, // enable
  input wire logic mains_sense_input_one, // sense
  input wire logic mains_sense_input_two, // sense
  input wire logic power_on_request, // request
  input wire logic [3:0] flag_out, // flag
  input wire logic [3:0] over_limit_output, // ov
  input wire logic [3:0] under_limit_output // uv
);
  logic [7:0] sel_a;
  logic [7:0] sel_b;
  logic [2:0] m1;
  logic [2:0] m3;
  logic [2:0] fou;
  // shadow of the select registers, written only through the bus
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_a <= 8'h00;
      sel_b <= 8'h00;
    end else if (wr_en && addr == `SEL_A_ADDR) begin
      sel_a <= wdata & `SEL_A_MASK;
    end else if (wr_en && addr == `SEL_B_ADDR) begin
      sel_b <= wdata & `SEL_B_MASK;
    end
  end
  assign m1 = sel_a[3:1];
  assign m3 = sel_b[4:2];
  assign fou = {flag_out[0], over_limit_output[0], under_limit_output[0]};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_sense_one;
    $past(nrst) && $past(m1) <= 3'h1 |-> mains_sense_input_one == $past(pin_level[0]) && !fou;
  endproperty
  a_sense_one: assert property (p_sense_one) else $error("sense one");
  property p_sense_two;
    $past(nrst) && $past(sel_a[7:5]) <= 3'h1 |-> mains_sense_input_two == $past(pin_level[1]);
  endproperty
  a_sense_two: assert property (p_sense_two) else $error("sense two");
  property p_req_low;
    $past(nrst) && $past(m3) == 3'h0 |-> power_on_request == !$past(pin_level[2]);
  endproperty
  a_req_low: assert property (p_req_low) else $error("request low");
  property p_req_high;
    $past(nrst) && $past(m3) == 3'h1 |-> power_on_request == $past(pin_level[2]);
  endproperty
  a_req_high: assert property (p_req_high) else $error("request high");
  property p_good;
    $past(nrst) && $past(sel_b[7:5]) <= 3'h1 |-> pin4_oe && pin4_out == $past(power_good_in);
  endproperty
  a_good: assert property (p_good) else $error("power good");
  property p_pos_ov;
    $past(nrst) && $past(m1) == 3'h2 |->
      ($past(above_1v15[0]) || fou == 3'h0) && (!$past(above_1v25[0]) || fou == 3'h6);
  endproperty
  a_pos_ov: assert property (p_pos_ov) else $error("pos ov");
  property p_pos_uv;
    $past(nrst) && $past(m1) == 3'h3 |->
      ($past(above_1v25[0]) || fou == 3'h1) && (!$past(above_1v35[0]) || fou == 3'h4);
  endproperty
  a_pos_uv: assert property (p_pos_uv) else $error("pos uv");
  property p_neg_ov;
    $past(nrst) && $past(m1) == 3'h4 |->
      ($past(above_1v25[0]) || fou == 3'h2) && (!$past(above_1v35[0]) || fou == 3'h4);
  endproperty
  a_neg_ov: assert property (p_neg_ov) else $error("neg ov");
  property p_neg_uv;
    $past(nrst) && $past(m1) == 3'h5 |->
      ($past(above_1v15[0]) || fou == 3'h0) && (!$past(above_1v25[0]) || fou == 3'h5);
  endproperty
  a_neg_uv: assert property (p_neg_uv) else $error("neg uv");
  property p_hold;
    $past(nrst) && $past(m1) >= 3'h2 && $past(m1) == $past(m1, 2) &&
      ($past(m1) inside {3'h3, 3'h4} ? $past(above_1v25[0]) && !$past(above_1v35[0])
        : $past(above_1v15[0]) && !$past(above_1v25[0])) |-> fou == $past(fou);
  endproperty
  a_hold: assert property (p_hold) else $error("band hold");
  c_sense: cover property (m1 <= 3'h1 && mains_sense_input_one);
  c_ov: cover property (m1 == 3'h2 && over_limit_output[0]);
  c_inv: cover property (m1 == 3'h7 && flag_out[0]);
endmodule
`default_nettype wire

// >>> test/monitor_pin_function_select_tb_top.sv
`include "mon_defs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module monitor_pin_function_select_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic power_good_in = 1'b0;
  logic [3:0][11:0] mv = {4{12'h44c}};
  logic [7:0] rdata;
  logic [3:0] pin_level, above_1v15, above_1v25, above_1v35;
  logic [3:0] flag_out, over_limit_output, under_limit_output;
  logic pin4_out, pin4_oe, mains_sense_input_one, mains_sense_input_two, power_on_request, irq;
  logic [11:0] lv;
  logic [4:0] ded;
  logic [11:0] fou_all;
  assign ded = {mains_sense_input_one, mains_sense_input_two, power_on_request,
    pin4_oe, pin4_out};
  assign fou_all = {flag_out, over_limit_output, under_limit_output};
  // {below-lower, above-upper} outputs per mode
  logic [5:0] dec_tab [8] = '{6'h00, 6'h00, 6'h06, 6'h0c, 6'h14, 6'h05, 6'h04, 6'h20};
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  supply_model supply_model_inst (.mv, .pin_level, .above_1v15, .above_1v25, .above_1v35);
  monitor_pin_function_select monitor_pin_function_select_inst (.clk, .nrst, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .pin_level, .above_1v15, .above_1v25, .above_1v35,
    .power_good_in, .pin4_out, .pin4_oe, .mains_sense_input_one, .mains_sense_input_two,
    .power_on_request, .flag_out, .over_limit_output, .under_limit_output, .irq);
  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  // idle cycle after each write keeps the strobe from being assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
    @(posedge clk);
  endtask
  task automatic ichk(input logic e);
    #1;
    `CHK("irq", e, irq)
    @(posedge clk);
  endtask
  task automatic dchk(input logic [11:0] v, input logic [2:0] e);
    mv <= {4{v}};
    repeat (3) @(posedge clk);
    #1;
    `CHK("fou", {{4{e[2]}}, {4{e[1]}}, {4{e[0]}}}, fou_all)
    `CHK("oe", 1'b0, pin4_oe)
    @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`SEL_A_ADDR, `SEL_A_RESET);
    rd(`SEL_B_ADDR, `SEL_B_RESET);
    power_good_in <= 1'b1;
    // pin three high here and under code 001 below, so only the polarity differs
    mv <= {12'h578, 12'h578, 12'h578, 12'h44c};
    repeat (3) @(posedge clk);
    #1;
    `CHK("ded", 5'h0b, ded)
    @(posedge clk);
    wr(`SEL_A_ADDR, 8'h22);
    wr(`SEL_B_ADDR, 8'h24);
    power_good_in <= 1'b0;
    mv <= {12'h44c, 12'h578, 12'h44c, 12'h578};
    repeat (3) @(posedge clk);
    #1;
    `CHK("ded", 5'h16, ded)
    @(posedge clk);
    wr(`SEL_A_ADDR, 8'hff);
    rd(`SEL_A_ADDR, 8'hee);
    rd(8'h20, 8'h00);
    for (int m = 2; m < 8; m++) begin
      lv = (m == 3 || m == 4) ? 12'h514 : 12'h4b0;
      wr(`SEL_A_ADDR, {m[2:0], 1'b0, m[2:0], 1'b0});
      wr(`SEL_B_ADDR, {m[2:0], m[2:0], 2'b00});
      dchk(12'h44c, dec_tab[m][5:3]);
      dchk(lv, dec_tab[m][5:3]);
      dchk(12'h578, dec_tab[m][2:0]);
      dchk(lv, dec_tab[m][2:0]);
    end
    wr(`SEL_A_ADDR, 8'h44);
    wr(`SEL_B_ADDR, 8'h48);
    dchk(12'h44c, 3'h0);
    wr(`STATUS_ADDR, 8'hff);
    wr(`MASK_ADDR, 8'h00);
    dchk(12'h578, 3'h6);
    rd(`STATUS_ADDR, 8'h0f);
    rd(`LIMIT_ADDR, 8'h0f);
    rd(`FLAG_ADDR, 8'h0f);
    ichk(1'b0);
    wr(`MASK_ADDR, 8'h01);
    ichk(1'b1);
    wr(`STATUS_ADDR, 8'h01);
    ichk(1'b0);
    rd(`STATUS_ADDR, 8'h0e);
    report_and_stop();
  end
endmodule
bind monitor_pin_function_select mon_pin_monitor mon_pin_monitor_inst (.clk, .nrst, .addr,
  .wdata, .wr_en, .pin_level, .above_1v15, .above_1v25, .above_1v35, .power_good_in,
  .pin4_out, .pin4_oe, .mains_sense_input_one, .mains_sense_input_two, .power_on_request,
  .flag_out, .over_limit_output, .under_limit_output);
`default_nettype wire

// >>> test/supply_model.sv
`timescale 1ns/10ps
`default_nettype none
module supply_model #(
  parameter logic [11:0] LOGIC_MV = 12'h4e2
) (
  input wire logic [3:0][11:0] mv, // pin voltage, mV
  output logic [3:0] pin_level, // logic level
  output logic [3:0] above_1v15, // cmp
  output logic [3:0] above_1v25, // cmp
  output logic [3:0] above_1v35 // cmp
);
  // ideal comparators, so the three results never disagree
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      above_1v15[i] = mv[i] > 12'h47e;
      above_1v25[i] = mv[i] > 12'h4e2;
      above_1v35[i] = mv[i] > 12'h546;
      pin_level[i] = mv[i] > LOGIC_MV;
    end
  end
endmodule
`default_nettype wire
